// ==== pkg/ssp_params.svh ====
/*
  register offsets, field positions, reset values and mode codes of the
  synchronous serial port block. assumes inclusion by the design module,
  the checker and the testbench.
*/
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

`define SSP_OFF_IRQ_FLAGS   12'h030
`define SSP_OFF_SHIFT_BUF   12'h04C
`define SSP_OFF_CONTROL     12'h050
`define SSP_OFF_PORT_C_DIR  12'h21C
`define SSP_OFF_IRQ_ENABLES 12'h230
`define SSP_OFF_SLAVE_ADDR  12'h24C
`define SSP_OFF_STATUS      12'h250
`define SSP_OFF_PORT_C_LAT  12'h01C
`define SSP_OFF_PORT_C_PIN  12'h020

`define SSP_IDX_IRQ_FLAGS   8'h0C
`define SSP_IDX_SHIFT_BUF   8'h13
`define SSP_IDX_CONTROL     8'h14
`define SSP_IDX_PORT_C_DIR  8'h87
`define SSP_IDX_IRQ_ENABLES 8'h8C
`define SSP_IDX_SLAVE_ADDR  8'h93
`define SSP_IDX_STATUS      8'h94

`define SSP_BIT_IRQ         3
`define SSP_BIT_SCL         3
`define SSP_BIT_SDA         4

`define SSP_RST_IRQ_FLAGS   8'h00
`define SSP_RST_CONTROL     8'h00
`define SSP_RST_PORT_C_DIR  8'hFF
`define SSP_RST_IRQ_ENABLES 8'h00
`define SSP_RST_SLAVE_ADDR  8'h00
`define SSP_RST_STATUS      8'h00
`define SSP_RST_SHIFT_BUF   8'h00
`define SSP_RST_PORT_C_LAT  8'h00

`define SSP_MODE_SPI_M4     4'h0
`define SSP_MODE_SPI_M16    4'h1
`define SSP_MODE_SPI_M64    4'h2
`define SSP_MODE_SPI_TMR    4'h3
`define SSP_MODE_SPI_S_SEL  4'h4
`define SSP_MODE_SPI_S      4'h5
`define SSP_MODE_I2C_S7     4'h6
`define SSP_MODE_I2C_S10    4'h7
`define SSP_MODE_I2C_FWM    4'hB
`define SSP_MODE_I2C_S7_SP  4'hE
`define SSP_MODE_I2C_S10_SP 4'hF

`endif

// ==== pkg/ssp_pkg.sv ====
/*
  types of the synchronous serial port block: status and control layouts
  and the slave byte engine states. assumes the params header beside it.
*/
package ssp_pkg;
  typedef struct packed {
    logic sample_phase_select;
    logic clock_edge_select;
    logic data_not_address;
    logic halt_seen;
    logic start_seen;
    logic read_not_write;
    logic address_update_needed;
    logic buffer_full_flag;
  } ssp_status_t;

  typedef struct packed {
    logic       write_collision_flag;
    logic       receive_overflow_flag;
    logic       serial_port_enable;
    logic       clock_polarity_release;
    logic [3:0] port_mode_select;
  } ssp_control_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ssp_wire_t;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_SHIFT,
    SSP_ACK,
    SSP_SKIP
  } ssp_state_t;
endpackage

// ==== logic/ssp_port.sv ====
/*
  synchronous serial port: apb register file, start and stop detection,
  firmware master pin drive and a two-wire slave byte receiver.
  assumes scl and sda pins arrive asynchronously; the bench resolves the
  open-drain wires from the enables.
*/
// How it works
// - reset or disable clears start and halt
// - stop sets halt, start sets start-seen
// - master mode pins driven only low, direction bit cleared
// - start, stop, byte done raise irq flag
// - master mode holds slave idle
// - irq enable while busy fires at stop
// - slave keeps receiving, acks if addressed, buffer empty, no overflow
// - sample phase bit is only stored, no spi sample logic
// - clock edge bit is only stored, no spi edge logic
// - data-not-address shows last byte kind
// - read-not-write holds matched address direction
// - ten-bit slave sets address update flag
// - buffer full tracks receive only, cleared by buffer read
// - buffer write during transmit sets collision
// - receive while full sets overflow
// - enable hands pins to serial port in two-wire modes only
// - clock polarity releases or stretches scl
// - spi mode codes leave plain port pins, no spi logic
// - mode codes pick two-wire slave variants
`timescale 1ns/1ns
`include "ssp_params.svh"
module ssp_port
  import ssp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             serial_port_irq
);
  ssp_status_t  status;
  ssp_control_t control;
  logic [7:0]   peripheral_irq_flags;
  logic [7:0]   peripheral_irq_enables;
  logic [7:0]   port_c_direction;
  logic [7:0]   port_c_latch;
  logic [7:0]   slave_address_register;
  logic [7:0]   serial_shift_buffer;
  logic [7:0]   serial_shift_register;
  ssp_wire_t    pin_meta;
  ssp_wire_t    pin_sync;
  ssp_wire_t    pin_prev;
  ssp_state_t   state;
  logic [3:0]   bit_count;
  logic         addressed;
  logic         second_addr;
  logic         start_det;
  logic         stop_det;
  logic         scl_rise;
  logic         scl_fall;
  logic         i2c_mode;
  logic         slave_on;
  logic         ten_bit;
  logic         enabled_i2c;
  logic         wr_acc;
  logic         rd_acc;
  logic         byte_done;
  logic         addr_match;
  logic         hold_scl;
  logic         ack_drive;
  logic         next_scl_oe;
  logic         next_sda_oe;
  logic [7:0]   rd_mux;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_comb begin
    unique case (control.port_mode_select)
      `SSP_MODE_I2C_S7, `SSP_MODE_I2C_S10, `SSP_MODE_I2C_FWM,
      `SSP_MODE_I2C_S7_SP, `SSP_MODE_I2C_S10_SP: i2c_mode = 1'b1;
      default: i2c_mode = 1'b0;
    endcase
  end
  assign enabled_i2c = control.serial_port_enable && i2c_mode;
  assign slave_on    = enabled_i2c && control.port_mode_select != `SSP_MODE_I2C_FWM;
  assign ten_bit     = control.port_mode_select == `SSP_MODE_I2C_S10 ||
                       control.port_mode_select == `SSP_MODE_I2C_S10_SP;

  // two-flop synchronisers for the bus wires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_prev <= '1;
    end else begin
      pin_meta <= '{scl: scl_in, sda: sda_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign start_det = pin_sync.scl && pin_prev.scl && pin_prev.sda && !pin_sync.sda;
  assign stop_det  = pin_sync.scl && pin_prev.scl && !pin_prev.sda && pin_sync.sda;
  assign scl_rise  = pin_sync.scl && !pin_prev.scl;
  assign scl_fall  = !pin_sync.scl && pin_prev.scl;

  // slave byte engine
  // byte ends on the eighth falling scl edge; the ack spans the ninth clock
  // seven-bit match ignores the direction bit, second ten-bit byte is whole
  assign addr_match = second_addr ? serial_shift_register == slave_address_register
                    : serial_shift_register[7:1] == slave_address_register[7:1];
  assign byte_done  = state == SSP_SHIFT && scl_fall && bit_count == 4'h8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                 <= SSP_IDLE;
      bit_count             <= 4'h0;
      serial_shift_register <= 8'h00;
      addressed             <= 1'b0;
      second_addr           <= 1'b0;
      ack_drive             <= 1'b0;
    end else if (!slave_on || stop_det) begin
      state     <= SSP_IDLE;
      addressed <= 1'b0;
      ack_drive <= 1'b0;
      bit_count <= 4'h0;
    end else if (start_det) begin
      state       <= SSP_SHIFT;
      bit_count   <= 4'h0;
      addressed   <= 1'b0;
      second_addr <= 1'b0;
      ack_drive   <= 1'b0;
    end else begin
      unique case (state)
        SSP_IDLE: begin
        end
        SSP_SHIFT: begin
          if (scl_rise) begin
            serial_shift_register <= {serial_shift_register[6:0], pin_sync.sda};
            bit_count             <= bit_count + 4'h1;
          end
          if (byte_done) begin
            state <= SSP_ACK;
            if (!addressed && addr_match && !status.buffer_full_flag &&
                !control.receive_overflow_flag) begin
              ack_drive <= 1'b1;
              addressed <= !ten_bit || second_addr;
              second_addr <= ten_bit && !second_addr;
            end else if (addressed) begin
              ack_drive <= !status.buffer_full_flag && !control.receive_overflow_flag;
            end else begin
              state <= SSP_SKIP;
            end
          end
        end
        SSP_ACK: begin
          if (scl_fall) begin
            ack_drive <= 1'b0;
            bit_count <= 4'h0;
            state     <= SSP_SHIFT;
          end
        end
        SSP_SKIP: begin
        end
      endcase
    end
  end

  // status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `SSP_RST_STATUS;
    end else begin
      if (!control.serial_port_enable) begin
        status.start_seen <= 1'b0;
        status.halt_seen  <= 1'b0;
      end else if (enabled_i2c && stop_det) begin
        status.halt_seen  <= 1'b1;
        status.start_seen <= 1'b0;
      end else if (enabled_i2c && start_det) begin
        status.start_seen <= 1'b1;
        status.halt_seen  <= 1'b0;
      end
      if (start_det || stop_det) begin
        status.read_not_write <= 1'b0;
      end else if (byte_done && !addressed && addr_match && !second_addr) begin
        status.read_not_write <= serial_shift_register[0];
      end
      if (byte_done && (addressed || addr_match)) begin
        status.data_not_address <= addressed;
        status.address_update_needed <= ten_bit && !addressed;
      end else if (wr_acc && paddr == `SSP_OFF_SLAVE_ADDR) begin
        status.address_update_needed <= 1'b0;
      end
      if (byte_done && (addressed || addr_match) && !status.buffer_full_flag &&
          !control.receive_overflow_flag) begin
        status.buffer_full_flag <= 1'b1;
      end else if (rd_acc && paddr == `SSP_OFF_SHIFT_BUF) begin
        status.buffer_full_flag <= 1'b0;
      end
      if (wr_acc && paddr == `SSP_OFF_STATUS) begin
        status.sample_phase_select <= pwdata[7];
        status.clock_edge_select   <= pwdata[6];
      end
    end
  end

  // control register; hardware sets win over software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `SSP_RST_CONTROL;
    end else begin
      if (wr_acc && paddr == `SSP_OFF_CONTROL) begin
        control <= pwdata[7:0];
      end
      if (wr_acc && paddr == `SSP_OFF_SHIFT_BUF && state == SSP_SHIFT &&
          addressed && status.read_not_write) begin
        control.write_collision_flag <= 1'b1;
      end
      if (byte_done && addressed && !status.read_not_write &&
          status.buffer_full_flag) begin
        control.receive_overflow_flag <= 1'b1;
      end
      if (byte_done && !addressed && addr_match && serial_shift_register[0] &&
          !ten_bit) begin
        control.clock_polarity_release <= 1'b0;
      end
    end
  end

  // other registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enables <= `SSP_RST_IRQ_ENABLES;
      port_c_direction       <= `SSP_RST_PORT_C_DIR;
      port_c_latch           <= `SSP_RST_PORT_C_LAT;
      slave_address_register <= `SSP_RST_SLAVE_ADDR;
      serial_shift_buffer    <= `SSP_RST_SHIFT_BUF;
    end else begin
      if (wr_acc && paddr == `SSP_OFF_IRQ_ENABLES) peripheral_irq_enables <= pwdata[7:0];
      if (wr_acc && paddr == `SSP_OFF_PORT_C_DIR) port_c_direction <= pwdata[7:0];
      if (wr_acc && paddr == `SSP_OFF_PORT_C_LAT) port_c_latch <= pwdata[7:0];
      if (wr_acc && paddr == `SSP_OFF_SLAVE_ADDR) slave_address_register <= pwdata[7:0];
      if (byte_done && (addressed || addr_match) && !status.buffer_full_flag &&
          !control.receive_overflow_flag) begin
        serial_shift_buffer <= serial_shift_register;
      end else if (wr_acc && paddr == `SSP_OFF_SHIFT_BUF) begin
        serial_shift_buffer <= pwdata[7:0];
      end
    end
  end

  // irq flag register; set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_flags <= `SSP_RST_IRQ_FLAGS;
    end else begin
      if (wr_acc && paddr == `SSP_OFF_IRQ_FLAGS) begin
        peripheral_irq_flags <= pwdata[7:0];
      end
      if (enabled_i2c && (start_det || stop_det || (byte_done && (addressed || addr_match)))) begin
        peripheral_irq_flags[`SSP_BIT_IRQ] <= 1'b1;
      end
    end
  end

  // pin drive: enable in a two-wire mode hands pins to the port, else plain port pins
  assign hold_scl = slave_on && !control.clock_polarity_release;
  always_comb begin
    if (enabled_i2c) begin
      next_scl_oe = !port_c_direction[`SSP_BIT_SCL] || hold_scl;
      next_sda_oe = !port_c_direction[`SSP_BIT_SDA] || ack_drive;
    end else begin
      next_scl_oe = !port_c_direction[`SSP_BIT_SCL];
      next_sda_oe = !port_c_direction[`SSP_BIT_SDA];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      scl_out <= enabled_i2c ? 1'b0 : port_c_latch[`SSP_BIT_SCL];
      sda_out <= enabled_i2c ? 1'b0 : port_c_latch[`SSP_BIT_SDA];
      scl_oe  <= next_scl_oe;
      sda_oe  <= next_sda_oe;
    end
  end

  // apb read path, zero-wait
  always_comb begin
    unique case (paddr)
      `SSP_OFF_IRQ_FLAGS:   rd_mux = peripheral_irq_flags;
      `SSP_OFF_SHIFT_BUF:   rd_mux = serial_shift_buffer;
      `SSP_OFF_CONTROL:     rd_mux = control;
      `SSP_OFF_PORT_C_DIR:  rd_mux = port_c_direction;
      `SSP_OFF_IRQ_ENABLES: rd_mux = peripheral_irq_enables;
      `SSP_OFF_SLAVE_ADDR:  rd_mux = slave_address_register;
      `SSP_OFF_STATUS:      rd_mux = status;
      `SSP_OFF_PORT_C_LAT:  rd_mux = port_c_latch;
      `SSP_OFF_PORT_C_PIN:  rd_mux = {3'h0, pin_sync.sda, pin_sync.scl, 3'h0};
      default:              rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      serial_port_irq <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= {24'h00_0000, rd_mux};
      pslverr <= psel && !penable && !(paddr inside {`SSP_OFF_IRQ_FLAGS, `SSP_OFF_SHIFT_BUF,
                 `SSP_OFF_CONTROL, `SSP_OFF_PORT_C_DIR, `SSP_OFF_IRQ_ENABLES,
                 `SSP_OFF_SLAVE_ADDR, `SSP_OFF_STATUS, `SSP_OFF_PORT_C_LAT,
                 `SSP_OFF_PORT_C_PIN});
      serial_port_irq <= peripheral_irq_flags[`SSP_BIT_IRQ] &&
                         peripheral_irq_enables[`SSP_BIT_IRQ];
    end
  end
endmodule

// ==== testbench/ssp_port_asserts.sv ====
/*
  port checker for the serial port block: apb timing, pin drive, irq.
  assumes bind onto ssp_port; control, direction and enable are
  shadowed from accepted apb writes.
*/
`timescale 1ns/1ns
`include "ssp_params.svh"
module ssp_port_asserts
  import ssp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        serial_port_irq
);
  logic [7:0] ctl;
  logic [7:0] dir;
  logic [7:0] ie;
  logic       wr_ok;
  logic       fwm;
  logic       sda_dir;
  logic       scl_dir;
  assign wr_ok   = psel && penable && pready && pwrite && !pslverr;
  assign fwm     = ctl[5] && (ctl[3:0] == `SSP_MODE_I2C_FWM);
  assign sda_dir = dir[`SSP_BIT_SDA];
  assign scl_dir = dir[`SSP_BIT_SCL];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= `SSP_RST_CONTROL;
      dir <= `SSP_RST_PORT_C_DIR;
      ie  <= `SSP_RST_IRQ_ENABLES;
    end else if (wr_ok) begin
      if (paddr == `SSP_OFF_CONTROL) ctl <= pwdata[7:0];
      if (paddr == `SSP_OFF_PORT_C_DIR) dir <= pwdata[7:0];
      if (paddr == `SSP_OFF_IRQ_ENABLES) ie <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence start_s;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence stop_s;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  pready_timing_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  pin_dir_a: assert property ($past(fwm) && $past(fwm, 2) |->
    (!sda_oe || !$past(sda_dir)) && (!scl_oe || !$past(scl_dir)))
    else $error("pin driven with direction set");
  drive_low_a: assert property ($past(fwm) && $past(fwm, 2) |-> !sda_out && !scl_out)
    else $error("pin driven high in master mode");
  start_irq_a: assert property ((fwm && ie[3]) ##0 start_s |-> ##[1:8] serial_port_irq)
    else $error("no irq after start");
  stop_irq_a: assert property ((fwm && ie[3]) ##0 stop_s |-> ##[1:8] serial_port_irq)
    else $error("no irq after stop");
  irq_enable_a: assert property (serial_port_irq |-> $past(ie[3]))
    else $error("irq while disabled");
endmodule

bind ssp_port ssp_port_asserts ssp_port_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
  .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe), .serial_port_irq(serial_port_irq));

// ==== testbench/ssp_bus_model.sv ====
/*
  another two-wire master on the bus, 80 ns bit clock, open drain.
  assumes the bench resolves its pulls with the pulled-up wires.
*/
`timescale 1ns/1ns
module ssp_bus_model (
  output logic      scl_low,
  output logic      sda_low,
  input  wire logic sda_line,
  output logic      ack_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    ack_low = 1'b0;
  end
  // only called with the bus idle or after a stop
  task automatic bus_start;
    #3 sda_low = 1'b0;
    #40 sda_low = 1'b1;
    #80;
  endtask
  task automatic bus_stop;
    #3 scl_low = 1'b1;
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #40 sda_low = 1'b0;
    #80;
  endtask
  // a one that reads back low means another master won: let go of both
  task automatic send_byte(input logic [7:0] b);
    logic lost;
    lost = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      scl_low = !lost;
      sda_low = !lost && !b[i];
      #40 scl_low = 1'b0;
      #20 lost = lost || (b[i] && !sda_line);
      #20;
    end
    scl_low = !lost;
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #20 ack_low = !sda_line;
    #20 scl_low = !lost;
  endtask
endmodule

// ==== testbench/tb.sv ====
/*
  testbench of the serial port: register table, mode codes, flags,
  master pin drive, slave ack and reset.
  assumes ssp_port, the bus model and the bound checker.
*/
`timescale 1ns/1ns
`include "ssp_params.svh"
module tb;
  import ssp_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [7:0]  d;
    logic [7:0]  x;
    logic        e;
  } ssp_row_t;
  logic        pclk, presetn, psel, penable, pwrite, tw, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
  logic        scl_low, sda_low, ack_low;
  wire         scl_line = !((scl_oe && !scl_out) || scl_low);
  wire         sda_line = !((sda_oe && !sda_out) || sda_low);
  int          fails, total_checks;
  logic [3:0]  modes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                              4'hB, 4'hE, 4'hF};
  ssp_row_t    rows [11] = '{
    '{`SSP_OFF_IRQ_FLAGS, 1'b0, 8'h00, 8'h00, 1'b0},
    '{`SSP_OFF_CONTROL, 1'b0, 8'h00, 8'h00, 1'b0},
    '{`SSP_OFF_PORT_C_DIR, 1'b0, 8'h00, 8'hFF, 1'b0},
    '{`SSP_OFF_IRQ_ENABLES, 1'b0, 8'h00, 8'h00, 1'b0},
    '{`SSP_OFF_SLAVE_ADDR, 1'b0, 8'h00, 8'h00, 1'b0},
    '{`SSP_OFF_STATUS, 1'b0, 8'h00, 8'h00, 1'b0},
    '{`SSP_OFF_SLAVE_ADDR, 1'b1, 8'h5A, 8'h5A, 1'b0},
    '{`SSP_OFF_STATUS, 1'b1, 8'hFF, 8'hC0, 1'b0},
    '{`SSP_OFF_STATUS, 1'b1, 8'h00, 8'h00, 1'b0},
    '{12'h004, 1'b1, 8'hFF, 8'h00, 1'b1},
    '{`SSP_OFF_SLAVE_ADDR, 1'b1, 8'h00, 8'h00, 1'b0}};
  ssp_port ssp_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .serial_port_irq(irq));
  ssp_bus_model ssp_bus_model_inst (.scl_low(scl_low), .sda_low(sda_low),
    .sda_line(sda_line), .ack_low(ack_low));
  always #5 pclk = !pclk;
  task automatic wrap_up;
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d}, rd, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] x);
    apb(a, 1'b0, 32'h0, rd, er);
    chk(rd, {24'h0, x});
  endtask
  task automatic tick;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(rows[i].a, 1'b1, {24'h0, rows[i].d}, rd, er);
      apb(rows[i].a, 1'b0, 32'h0, rd, er);
      chk(rd, {24'h0, rows[i].x});
      chk(er, rows[i].e);
    end
    foreach (modes[i]) begin
      tw = modes[i] inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
      wr(`SSP_OFF_CONTROL, {4'h3, modes[i]});
      ssp_bus_model_inst.bus_start();
      rdc(`SSP_OFF_CONTROL, {4'h3, modes[i]});
      rdc(`SSP_OFF_STATUS, {4'h0, tw, 3'h0});
      ssp_bus_model_inst.bus_stop();
      rdc(`SSP_OFF_STATUS, {3'h0, tw, 4'h0});
      wr(`SSP_OFF_CONTROL, 8'h00);
      rdc(`SSP_OFF_STATUS, 8'h00);
    end
    wr(`SSP_OFF_CONTROL, 8'h3B);
    ssp_bus_model_inst.bus_start();
    wr(`SSP_OFF_IRQ_FLAGS, 8'h00);
    wr(`SSP_OFF_IRQ_ENABLES, 8'h08);
    chk(irq, 1'b0);
    ssp_bus_model_inst.bus_stop();
    chk(irq, 1'b1);
    rdc(`SSP_OFF_IRQ_FLAGS, 8'h08);
    wr(`SSP_OFF_IRQ_FLAGS, 8'h00);
    ssp_bus_model_inst.bus_start();
    chk(irq, 1'b1);
    ssp_bus_model_inst.bus_stop();
    wr(`SSP_OFF_PORT_C_LAT, 8'h18);
    wr(`SSP_OFF_PORT_C_DIR, 8'hE7);
    tick();
    chk({scl_oe, scl_out, sda_oe, sda_out, sda_line}, 5'b10100);
    wr(`SSP_OFF_PORT_C_DIR, 8'hFF);
    tick();
    chk({scl_oe, sda_oe, sda_line}, 3'b001);
    wr(`SSP_OFF_PORT_C_DIR, 8'hE7);
    wr(`SSP_OFF_CONTROL, 8'h00);
    tick();
    chk({scl_oe, scl_out, sda_oe, sda_out}, 4'b1111);
    wr(`SSP_OFF_PORT_C_DIR, 8'hFF);
    wr(`SSP_OFF_IRQ_ENABLES, 8'h00);
    wr(`SSP_OFF_CONTROL, 8'h36);
    wr(`SSP_OFF_IRQ_FLAGS, 8'h00);
    ssp_bus_model_inst.bus_start();
    ssp_bus_model_inst.send_byte(8'h00);
    chk(ack_low, 1'b1);
    rdc(`SSP_OFF_STATUS, 8'h09);
    rdc(`SSP_OFF_SHIFT_BUF, 8'h00);
    rdc(`SSP_OFF_STATUS, 8'h08);
    rdc(`SSP_OFF_IRQ_FLAGS, 8'h08);
    tick();
    ssp_bus_model_inst.send_byte(8'hA5);
    chk(ack_low, 1'b1);
    tick();
    ssp_bus_model_inst.send_byte(8'h3C);
    chk(ack_low, 1'b0);
    rdc(`SSP_OFF_STATUS, 8'h29);
    rdc(`SSP_OFF_CONTROL, 8'h76);
    rdc(`SSP_OFF_SHIFT_BUF, 8'hA5);
    wr(`SSP_OFF_CONTROL, 8'h36);
    ssp_bus_model_inst.bus_stop();
    rdc(`SSP_OFF_STATUS, 8'h30);
    wr(`SSP_OFF_CONTROL, 8'h37);
    wr(`SSP_OFF_SLAVE_ADDR, 8'hF0);
    ssp_bus_model_inst.bus_start();
    ssp_bus_model_inst.send_byte(8'hF0);
    chk(ack_low, 1'b1);
    rdc(`SSP_OFF_STATUS, 8'h0B);
    wr(`SSP_OFF_SLAVE_ADDR, 8'h00);
    rdc(`SSP_OFF_STATUS, 8'h09);
    ssp_bus_model_inst.bus_stop();
    wr(`SSP_OFF_CONTROL, 8'h27);
    tick();
    chk({scl_oe, scl_line}, 2'b10);
    wr(`SSP_OFF_CONTROL, 8'h37);
    tick();
    chk({scl_oe, scl_line}, 2'b01);
    presetn <= 1'b0;
    tick();
    chk({pready, pslverr, scl_oe, sda_oe, irq}, 5'b00000);
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(`SSP_OFF_CONTROL, 8'h00);
    rdc(`SSP_OFF_STATUS, 8'h00);
    wrap_up();
  end
endmodule
